// ==== logic/lsw_pkg.sv ====
// Constants, types and frame layout of the lamp switch control logic
package lsw_pkg;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam int unsigned FRAME_W  = 16;
	localparam int unsigned KICK_BIT = 15;
	localparam int unsigned ADDR_HI  = 14;
	localparam int unsigned ADDR_LO  = 10;
	localparam int unsigned DATA_W   = 10;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_PWM  = 5'h01;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	// Control register fields
	localparam int unsigned CTRL_ON_LO = 0;
	localparam int unsigned CTRL_VFE   = 4;
	localparam int unsigned CTRL_OVE   = 5;
	localparam logic [9:0] CTRL_RST    = 10'h000;
	// Dimming register fields
	localparam int unsigned PWM_DUTY_HI = 6;
	localparam int unsigned PWM_EN_BIT  = 7;
	localparam int unsigned PWM_FSEL_LO = 8;
	localparam logic [9:0] PWM_RST      = 10'h000;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_KHZ    = 25000;
	localparam int unsigned PWM_STEPS  = 128;
	localparam int unsigned PWM_F_MIN  = 100;
	localparam int unsigned WDTO_MS    = 10;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_SLEEP    = 2'h0,
		MODE_NORMAL   = 2'h1,
		MODE_FAILSAFE = 2'h3,
		MODE_FAULT    = 2'h2
	} lsw_mode_t;
	typedef struct packed {
		logic [3:0] lamp_req;
		logic       rst_pin;
		logic       wake_pin;
		logic       failsafe_strap;
		logic       vdd_fail;
		logic [3:0] overcurrent_flag;
		logic [3:0] overtemperature_flag;
		logic [3:0] severe_short_flag;
		logic       undervoltage_flag;
		logic       supply_high_flag;
	} lsw_pins_t;
endpackage

// ==== logic/lsw_top.sv ====
// Serial slave port and operating-mode controller of the lamp switch
`timescale 1ns/10ps
module lsw_top import lsw_pkg::*; #(
	parameter int unsigned WDTO_CYC = WDTO_MS * CLK_KHZ
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Serial link
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic       si_in,
	output logic            so_out,
	output logic            so_oe_out,
	// Device pins and analog flags
	input  wire lsw_pins_t  pins_in,
	// Lamps and status
	output logic [3:0]      lamp_output_out,
	output logic            fault_flag_out,
	output logic            fault_flag_oe_out,
	output logic            reg_en_out,
	output lsw_mode_t       mode_out
);
	// ****************************************
	// Link side, serial clock domain
	// ****************************************
	logic [15:0] rx_sh_ff, nxt_rx_sh;
	logic [4:0]  rx_cnt_ff, nxt_rx_cnt;
	logic [3:0]  tx_cnt_ff, nxt_tx_cnt;
	logic        so_ff, nxt_so;
	logic        so_oe_ff;
	logic        clr_ff, nxt_clr;
	logic [15:0] tx_hold_ff, nxt_tx_hold;
	logic        tx_rst;

	assign tx_rst = cs_n_in | ~rstn_in;

	always_comb begin
		nxt_rx_sh  = {rx_sh_ff[14:0], si_in};
		nxt_rx_cnt = (rx_cnt_ff == 5'h1f) ? rx_cnt_ff : rx_cnt_ff + 5'h01;
		nxt_tx_cnt = tx_cnt_ff + 4'h1;
		nxt_so     = tx_hold_ff[4'hf - tx_cnt_ff];
	end

	// Input bits sampled on the falling edge; cleared once the frame is taken
	always_ff @(negedge sclk_in or posedge clr_ff) begin
		if (clr_ff) begin
			rx_sh_ff  <= 16'h0000;
			rx_cnt_ff <= 5'h00;
		end else begin
			rx_sh_ff  <= nxt_rx_sh;
			rx_cnt_ff <= nxt_rx_cnt;
		end
	end

	// Output bit changes on the rising edge; driver released with select
	always_ff @(posedge sclk_in or posedge tx_rst) begin
		if (tx_rst) begin
			tx_cnt_ff <= 4'h0;
			so_ff     <= 1'b0;
			so_oe_ff  <= 1'b0;
		end else begin
			tx_cnt_ff <= nxt_tx_cnt;
			so_ff     <= nxt_so;
			so_oe_ff  <= 1'b1;
		end
	end

	assign so_out    = so_ff;
	assign so_oe_out = so_oe_ff;

	// ****************************************
	// Synchronisers into the oscillator domain
	// ****************************************
	logic [2:0] cs_s_ff;
	lsw_pins_t  pin_s1_ff, pin_s2_ff;
	logic       cs_rise, cs_fall;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cs_s_ff   <= 3'h7;
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			cs_s_ff   <= {cs_s_ff[1:0], cs_n_in};
			pin_s1_ff <= pins_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign cs_rise = cs_s_ff[1] & ~cs_s_ff[2];
	assign cs_fall = ~cs_s_ff[1] & cs_s_ff[2];

	// ****************************************
	// Mode terms
	// ****************************************
	lsw_mode_t  mode_ff, nxt_mode;
	logic [9:0] ctrl_ff, nxt_ctrl, pwm_ff, nxt_pwm;
	logic [31:0] wd_cnt_ff, nxt_wd_cnt;
	logic       wd_to_ff, nxt_wd_to, kick_ff, nxt_kick;
	logic       vfail_ff, nxt_vfail;
	logic [3:0] lamp_ff, nxt_lamp;
	logic       fault_oe_ff, nxt_fault_oe;
	logic       reg_en_ff, nxt_reg_en;
	logic       frm_ok, kick_bit, wake_up, fail, fault, strap_open, ov_trip;
	logic [3:0] ch_fault, ch_off, norm_drv;
	logic [15:0] status;
	logic [4:0] addr;
	logic [9:0] wdata;
	logic [15:0] pre_cnt_ff, nxt_pre_cnt;
	logic [6:0] step_ff, nxt_step;
	logic       pwm_on;

	// Counts per dimming step for 100, 200, 300 or 400 Hz
	function automatic logic [15:0] pwm_div(input logic [1:0] sel);
		int unsigned d;
		d = CLK_KHZ * 1000 / (PWM_STEPS * PWM_F_MIN * (int'(sel) + 1)) - 1;
		return d[15:0];
	endfunction

	assign frm_ok     = cs_rise && rx_cnt_ff == FRAME_BITS;
	assign kick_bit   = rx_sh_ff[KICK_BIT];
	assign addr       = rx_sh_ff[ADDR_HI:ADDR_LO];
	assign wdata      = rx_sh_ff[DATA_W-1:0];
	assign strap_open = pin_s2_ff.failsafe_strap;
	assign wake_up    = pin_s2_ff.rst_pin | pin_s2_ff.wake_pin | (|pin_s2_ff.lamp_req);
	assign fail       = vfail_ff | (wd_to_ff & strap_open);
	assign ch_fault   = pin_s2_ff.overcurrent_flag | pin_s2_ff.overtemperature_flag
	                  | pin_s2_ff.severe_short_flag;
	assign ov_trip    = pin_s2_ff.supply_high_flag & ctrl_ff[CTRL_OVE];
	assign fault      = (|ch_fault) | pin_s2_ff.undervoltage_flag | ov_trip;
	assign ch_off     = ch_fault | {4{pin_s2_ff.undervoltage_flag | ov_trip}};
	assign pwm_on     = step_ff <= pwm_ff[PWM_DUTY_HI:0];
	assign status     = {mode_ff, ch_fault, pin_s2_ff.undervoltage_flag, pin_s2_ff.supply_high_flag,
	                     pin_s2_ff.vdd_fail, wd_to_ff, strap_open, 1'b0, lamp_ff};

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			norm_drv[i] = ctrl_ff[CTRL_ON_LO+i] & (~pwm_ff[PWM_EN_BIT] | pwm_on);
		end
		// Mode selection, Sleep first
		if (!wake_up) begin
			nxt_mode = MODE_SLEEP;
		end else if (fault) begin
			nxt_mode = MODE_FAULT;
		end else if (fail) begin
			nxt_mode = MODE_FAILSAFE;
		end else begin
			nxt_mode = MODE_NORMAL;
		end
		// Serial frame transfer
		nxt_tx_hold = cs_fall ? status : tx_hold_ff;
		// Receive register stays cleared from select rise until the next select fall
		nxt_clr     = cs_rise ? 1'b1 : (cs_fall ? 1'b0 : clr_ff);
		nxt_ctrl    = ctrl_ff;
		nxt_pwm     = pwm_ff;
		if (frm_ok && addr == ADDR_CTRL) begin
			nxt_ctrl = wdata;
		end else if (frm_ok && addr == ADDR_PWM) begin
			nxt_pwm = wdata;
		end
		case (nxt_mode)
			MODE_SLEEP: begin
				nxt_ctrl = CTRL_RST;
				nxt_pwm  = PWM_RST;
			end
			MODE_FAILSAFE: begin
				// Supply-loss and overvoltage enables survive so the cause stays visible
				nxt_ctrl = (ctrl_ff & 10'h030) | (CTRL_RST & 10'h3cf);
				nxt_pwm  = PWM_RST;
			end
			default: begin
			end
		endcase
		// Watchdog: restarted by a kick-bit toggle
		nxt_kick   = frm_ok ? kick_bit : kick_ff;
		nxt_wd_cnt = wd_cnt_ff + 32'h1;
		if (mode_ff == MODE_SLEEP || !strap_open || (frm_ok && kick_bit != kick_ff)) begin
			nxt_wd_cnt = 32'h0;
		end else if (wd_to_ff) begin
			nxt_wd_cnt = wd_cnt_ff;
		end
		nxt_wd_to = wd_to_ff;
		if (!strap_open || mode_ff == MODE_SLEEP || (frm_ok && kick_bit)) begin
			nxt_wd_to = 1'b0;
		end
		if (strap_open && mode_ff != MODE_SLEEP && wd_cnt_ff == WDTO_CYC - 1) begin
			nxt_wd_to = 1'b1;
		end
		// Supply-loss fail holds until supply is back and a frame sets the kick bit, or until Sleep with no wake-up
		nxt_vfail = vfail_ff;
		if (!pin_s2_ff.vdd_fail && frm_ok && kick_bit) begin
			nxt_vfail = 1'b0;
		end
		if (pin_s2_ff.vdd_fail && ctrl_ff[CTRL_VFE]) begin
			nxt_vfail = 1'b1;
		end
		if (mode_ff == MODE_SLEEP && !wake_up) begin
			nxt_vfail = 1'b0;
		end
		// Dimming timebase
		nxt_pre_cnt = pre_cnt_ff + 16'h0001;
		nxt_step    = step_ff;
		if (pre_cnt_ff >= pwm_div(pwm_ff[PWM_FSEL_LO+:2])) begin
			nxt_pre_cnt = 16'h0000;
			nxt_step    = step_ff + 7'h01;
		end
		// Lamp drive
		case (nxt_mode)
			MODE_NORMAL:   nxt_lamp = norm_drv;
			MODE_FAILSAFE: nxt_lamp = pin_s2_ff.lamp_req;
			MODE_FAULT:    nxt_lamp = (fail ? pin_s2_ff.lamp_req : norm_drv) & ~ch_off;
			default:       nxt_lamp = 4'h0;
		endcase
		nxt_fault_oe = nxt_mode == MODE_FAULT;
		// Regulator enable registered so the pin never glitches on mode decode
		nxt_reg_en   = nxt_mode != MODE_SLEEP;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_ff     <= MODE_SLEEP;
			tx_hold_ff  <= 16'h0000;
			clr_ff      <= 1'b1;
			ctrl_ff     <= CTRL_RST;
			pwm_ff      <= PWM_RST;
			kick_ff     <= 1'b0;
			wd_cnt_ff   <= 32'h0;
			wd_to_ff    <= 1'b0;
			vfail_ff    <= 1'b0;
			pre_cnt_ff  <= 16'h0000;
			step_ff     <= 7'h00;
			lamp_ff     <= 4'h0;
			fault_oe_ff <= 1'b0;
			reg_en_ff   <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			tx_hold_ff  <= nxt_tx_hold;
			clr_ff      <= nxt_clr;
			ctrl_ff     <= nxt_ctrl;
			pwm_ff      <= nxt_pwm;
			kick_ff     <= nxt_kick;
			wd_cnt_ff   <= nxt_wd_cnt;
			wd_to_ff    <= nxt_wd_to;
			vfail_ff    <= nxt_vfail;
			pre_cnt_ff  <= nxt_pre_cnt;
			step_ff     <= nxt_step;
			lamp_ff     <= nxt_lamp;
			fault_oe_ff <= nxt_fault_oe;
			reg_en_ff   <= nxt_reg_en;
		end
	end

	assign lamp_output_out   = lamp_ff;
	assign fault_flag_out    = 1'b0;
	assign fault_flag_oe_out = fault_oe_ff;
	assign reg_en_out        = reg_en_ff;
	assign mode_out          = mode_ff;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	AST_SLEEP_OFF: assert property (mode_ff == MODE_SLEEP |-> lamp_ff == 4'h0)
		else $error("Lamp on in Sleep");
	AST_WAKE_TERM: assert property (!wake_up |=> mode_ff == MODE_SLEEP)
		else $error("No wake-up but not Sleep");
	AST_FS_LAMPS: assert property (mode_ff == MODE_FAILSAFE |-> lamp_ff == $past(pin_s2_ff.lamp_req))
		else $error("Fail-safe lamps do not follow inputs");
	AST_FAULT_MODE: assert property (wake_up && fault |=> mode_ff == MODE_FAULT)
		else $error("Fault mode missed");
	AST_FAIL_MODE: assert property (wake_up && fail && !fault |=> mode_ff == MODE_FAILSAFE)
		else $error("Fail-safe mode missed");
	AST_NORMAL: assert property (wake_up && !fail && !fault |=> mode_ff == MODE_NORMAL)
		else $error("Normal mode missed");
	AST_SLEEP_CFG: assert property (mode_ff == MODE_SLEEP |-> ctrl_ff == 10'h000 && pwm_ff == 10'h000)
		else $error("Configuration not cleared in Sleep");
	AST_WD_TO: assert property (strap_open && mode_ff != MODE_SLEEP && wd_cnt_ff == WDTO_CYC - 1
		##1 strap_open |-> wd_to_ff ##1 mode_ff != MODE_NORMAL || !wake_up)
		else $error("Watchdog timeout not acted on");
	AST_CS_LOAD: assert property (cs_fall |=> tx_hold_ff == $past(status))
		else $error("Status not loaded at select fall");
	AST_SO_HIZ: assert property (cs_s_ff[2] && cs_s_ff[1] |-> !so_oe_ff)
		else $error("Serial output driven with select high");
	AST_VFAIL: assert property (pin_s2_ff.vdd_fail && ctrl_ff[CTRL_VFE] |=> fail)
		else $error("Enabled supply loss did not raise fail");
	AST_FAULT_PIN: assert property (fault_oe_ff == (mode_ff == MODE_FAULT))
		else $error("Fault pin does not match Fault mode");
	AST_NORM_LAMPS: assert property (mode_ff == MODE_NORMAL |-> lamp_ff == $past(norm_drv))
		else $error("Normal lamps not from serial settings");
	AST_FRAME_WR: assert property (frm_ok && addr == ADDR_CTRL && nxt_mode != MODE_SLEEP && nxt_mode != MODE_FAILSAFE |=> ctrl_ff == $past(wdata))
		else $error("Control frame not written");

	COV_NORMAL:   cover property (mode_ff == MODE_SLEEP ##1 mode_ff == MODE_NORMAL);
	COV_FAILSAFE: cover property (mode_ff == MODE_NORMAL ##1 mode_ff == MODE_FAILSAFE);
	COV_FRAME:    cover property (frm_ok && addr == ADDR_CTRL);
	COV_FAULT:    cover property (mode_ff == MODE_FAULT && lamp_ff != 4'h0);
	COV_SLEEP:    cover property (mode_ff != MODE_SLEEP ##1 mode_ff == MODE_SLEEP);
endmodule

// ==== verif/lsw_host.sv ====
// Host serial master model facing the lamp switch serial port
`timescale 1ns/10ps
module lsw_host (
	// Serial link
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      si_out,
	input  wire logic so_in
);
	// ****
	// Frame engine
	// ****
	// Clock stands low between frames, so edges exist only inside a frame
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out   = 1'b0;
	end
	// Callers pass n=16 except when a frame is meant to be refused
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		#13;
		cs_n_out = 1'b0;
		#250;
		// Input bit moves with the rising edge so it stands a half period on each side of the falling edge
		for (int i = 0; i < n; i++) begin
			#40 sclk_out = 1'b1;
			si_out = w[15 - i];
			#40 rx[15 - i] = so_in;
			sclk_out = 1'b0;
		end
		#60 cs_n_out = 1'b1;
		// Released data line flips so a stale bit never looks valid
		si_out = ~si_out;
		#1000;
	endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench of the lamp switch serial port and mode control
`timescale 1ns/10ps
module testbench import lsw_pkg::*;;
	logic        clk_in;
	logic        rstn_in;
	logic        sclk, cs_n, si, so, so_oe, ffo, ffoe, reg_en;
	lsw_pins_t   pins;
	logic [3:0]  lamps;
	lsw_mode_t   mode;
	logic [9:0]  st;
	logic [15:0] rx_seen;
	logic [9:0]  exp_st[$];
	logic [15:0] exp_rx[$];
	event        ev_st, ev_rx;
	int          n_errors, checks, cyc, seed;
	logic [31:0] r;
	assign st = {ffo, so_oe, ffoe, reg_en, mode, lamps};
	lsw_top #(.WDTO_CYC(50)) u_lsw_top (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.si_in(si), .so_out(so), .so_oe_out(so_oe), .pins_in(pins), .lamp_output_out(lamps),
		.fault_flag_out(ffo), .fault_flag_oe_out(ffoe), .reg_en_out(reg_en), .mode_out(mode));
	lsw_host u_lsw_host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so));
	// ****
	// Checking
	// ****
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp_st(input logic [9:0] e);
		checks++;
		if (st !== e) begin
			n_errors++;
			$display("CHECK FAILED state expected %h seen %h", e, st);
		end
	endtask
	task automatic cmp_rx(input logic [15:0] e);
		checks++;
		if (rx_seen !== e) begin
			n_errors++;
			$display("CHECK FAILED status word expected %h seen %h", e, rx_seen);
		end
	endtask
	always @(ev_st) cmp_st(exp_st.pop_front());
	always @(ev_rx) cmp_rx(exp_rx.pop_front());
	// Sample off the edge so flop updates have landed
	task automatic expect_st(input lsw_mode_t m, input logic [3:0] l);
		#5;
		exp_st.push_back({2'b00, m == MODE_FAULT, m != MODE_SLEEP, m, l});
		-> ev_st;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic frame(input logic [15:0] w, input int n, input logic [15:0] e);
		u_lsw_host.xfer(w, n, rx_seen);
		if (n == 16) begin
			exp_rx.push_back(e);
			-> ev_rx;
		end
		wt(2);
	endtask
	// ****
	// Stimulus
	// ****
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Hang guard, well above the few hundred cycles the sequence needs
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		seed = 56;
		cyc = 0;
		n_errors = 0;
		checks = 0;
		rstn_in = 1'b0;
		pins = '0;
		wt(4);
		rstn_in <= 1'b1;
		wt(6);
		expect_st(MODE_SLEEP, 4'h0);
		@(posedge clk_in);
		pins.wake_pin <= 1'b1;
		wt(6);
		expect_st(MODE_NORMAL, 4'h0);
		frame(16'h800a, 16, 16'h4000);
		expect_st(MODE_NORMAL, 4'ha);
		frame(16'h0005, 15, 16'h0000);
		expect_st(MODE_NORMAL, 4'ha);
		frame(16'h0805, 16, 16'h400a);
		expect_st(MODE_NORMAL, 4'ha);
		r = $random(seed);
		@(posedge clk_in);
		pins.failsafe_strap <= 1'b1;
		pins.lamp_req <= r[3:0];
		wt(70);
		expect_st(MODE_FAILSAFE, r[3:0]);
		@(posedge clk_in);
		pins.lamp_req <= 4'hf;
		// Bit 0 is overvoltage without its enable, bit 1 undervoltage, then each channel flag
		for (int j = 0; j < 14; j++) begin
			@(posedge clk_in);
			pins[13:0] <= 14'h0001 << j;
			wt(6);
			if (j == 0)
				expect_st(MODE_FAILSAFE, 4'hf);
			else
				expect_st(MODE_FAULT, (j == 1) ? 4'h0 : 4'hf & ~(4'h1 << ((j - 2) % 4)));
		end
		@(posedge clk_in);
		pins[13:0] <= 14'h0000;
		pins.failsafe_strap <= 1'b0;
		wt(6);
		expect_st(MODE_NORMAL, 4'h0);
		frame(16'h8020, 16, 16'h4000);
		@(posedge clk_in);
		pins.supply_high_flag <= 1'b1;
		wt(6);
		expect_st(MODE_FAULT, 4'h0);
		@(posedge clk_in);
		pins.supply_high_flag <= 1'b0;
		wt(6);
		expect_st(MODE_NORMAL, 4'h0);
		frame(16'h0010, 16, 16'h4000);
		@(posedge clk_in);
		pins.vdd_fail <= 1'b1;
		wt(6);
		expect_st(MODE_FAILSAFE, 4'hf);
		@(posedge clk_in);
		pins <= '0;
		wt(6);
		expect_st(MODE_SLEEP, 4'h0);
		wt(2);
		give_verdict();
	end
endmodule
